// *** design/pots_pkg.sv ***
// pots_pkg: register map, field layout and carrier types of the pattern output trigger select block.
// assumes an APB slave with 32-bit data, one aligned word per register.
package pots_pkg;
    localparam int unsigned POTS_GROUPS = 4;
    localparam int unsigned POTS_PINS = 16;
    localparam logic [11:0] POTS_ADDR_SEL = 12'h000;
    localparam logic [11:0] POTS_ADDR_MODE = 12'h004;
    localparam logic [11:0] POTS_ADDR_NEXT_VAL = 12'h008;
    localparam logic [11:0] POTS_ADDR_NEXT_EN = 12'h00C;
    localparam logic [11:0] POTS_ADDR_PINS = 12'h010;
    localparam logic [7:0] POTS_SEL_RESET = 8'hFF;
    localparam logic [15:0] POTS_NEXT_VAL_RESET = 16'h0000;
    localparam logic [15:0] POTS_NEXT_EN_RESET = 16'h0000;
    localparam logic [15:0] POTS_PINS_RESET = 16'h0000;
    localparam int unsigned POTS_MODE_NONOVL_BIT = 0;
    localparam logic POTS_MODE_RESET = 1'b0;
    localparam logic [31:0] POTS_RDATA_RESET = 32'h00000000;

    typedef struct packed {
        logic [3:0] match_a;
        logic [3:0] match_b;
    } pots_match_t;

    typedef struct packed {
        logic [7:0] sel;
        logic nonovl;
        logic [15:0] next_val;
        logic [15:0] next_en;
        logic [15:0] pins;
        logic [31:0] rdata;
    } pots_state_t;
endpackage : pots_pkg

// *** design/pots_top.sv ***
// pots_top: trigger selection, group 3 mode and pattern pin update with an APB register file.
// assumes compare match inputs are one-cycle pulses synchronous to pclk.
//
// Notes on behaviour
// - select bits 1:0 pick trigger for pins 3:0
// - select bits 3:2 pick trigger for pins 7:4
// - select bits 5:4 pick trigger for pins 11:8
// - group 3 normal: update on match A only
// - group 3 non-overlap: match A and B govern
// - select bits 7:6 pick trigger for pins 15:12
// - enabled pins take next value on trigger
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pots_top #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pots_pkg::pots_match_t match,
    output logic [15:0] pattern_pin
);
    if (CHANNELS != 4)
    begin : g_bad_channels
        $error("pots_top serves exactly four timer channels");
    end

    // all registered state of the block
    pots_pkg::pots_state_t st;
    pots_pkg::pots_state_t next_st;

    // trigger pulses after channel selection, one per group
    logic [3:0] grp_a;
    logic [3:0] grp_b;

    // load masks of groups 0 to 2 and of group 3
    logic [11:0] grp_mask;
    logic [3:0] grp3_mask;
    logic [3:0] g3_fall;
    logic [3:0] g3_rise;

    // pins that take their next value at this edge
    logic [15:0] load_val;
    logic [15:0] load_mask;

    // bus decode
    logic setup_phase;
    logic write_access;
    logic [4:0] rd_hit;
    logic [4:0] wr_hit;

    // picks the match pulse of the channel coded in a 2-bit field
    function automatic logic pick(input logic [3:0] m, input logic [1:0] code);
        pick = m[code];
    endfunction : pick

    // one-hot register decode: select, mode, next value, next enable, pins
    function automatic logic [4:0] decode(input logic [11:0] a);
        decode = 5'h00;
        case (a)
            pots_pkg::POTS_ADDR_SEL:
            begin
                decode = 5'h01;
            end
            pots_pkg::POTS_ADDR_MODE:
            begin
                decode = 5'h02;
            end
            pots_pkg::POTS_ADDR_NEXT_VAL:
            begin
                decode = 5'h04;
            end
            pots_pkg::POTS_ADDR_NEXT_EN:
            begin
                decode = 5'h08;
            end
            pots_pkg::POTS_ADDR_PINS:
            begin
                decode = 5'h10;
            end
            default:
            begin
                decode = 5'h00;
            end
        endcase
    endfunction : decode

    // channel selection per group
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_grp
        assign grp_a[g] = pick(match.match_a, st.sel[2*g +: 2]);
        assign grp_b[g] = pick(match.match_b, st.sel[2*g +: 2]);
    end

    // groups 0 to 2 always load on match A
    for (g = 0; g < 3; g++)
    begin : g_plain
        assign grp_mask[4*g +: 4] = {4{grp_a[g]}};
    end

    // non-overlap: match A loads pins headed low, match B pins headed high
    assign g3_fall = {4{grp_a[3]}} & ~st.next_val[15:12];
    assign g3_rise = {4{grp_b[3]}} & st.next_val[15:12];

    always_comb
    begin
        if (st.nonovl)
        begin
            grp3_mask = g3_fall | g3_rise;
        end
        else
        begin
            grp3_mask = {4{grp_a[3]}};
        end
    end

    always_comb
    begin
        load_val = st.next_val;
        load_mask = {grp3_mask, grp_mask} & st.next_en;
    end

    // bus phases and decode
    always_comb
    begin
        setup_phase = psel && !penable;
        write_access = psel && penable && pwrite;
        rd_hit = decode(paddr);
        wr_hit = decode(paddr);
    end

    // next state: pin update, read capture and register writes
    always_comb
    begin
        next_st = st;
        // one update per sampled match pulse
        next_st.pins = (st.pins & ~load_mask) | (load_val & load_mask);
        if (setup_phase)
        begin
            // unmapped reads return zero
            next_st.rdata = 32'h00000000;
            if (rd_hit[0])
            begin
                next_st.rdata = {24'h000000, st.sel};
            end
            if (rd_hit[1])
            begin
                next_st.rdata = {31'h00000000, st.nonovl};
            end
            if (rd_hit[2])
            begin
                next_st.rdata = {16'h0000, st.next_val};
            end
            if (rd_hit[3])
            begin
                next_st.rdata = {16'h0000, st.next_en};
            end
            if (rd_hit[4])
            begin
                next_st.rdata = {16'h0000, st.pins};
            end
        end
        // pins register is read only; writes there fall through
        if (write_access)
        begin
            if (wr_hit[0])
            begin
                next_st.sel = pwdata[7:0];
            end
            if (wr_hit[1])
            begin
                next_st.nonovl = pwdata[pots_pkg::POTS_MODE_NONOVL_BIT];
            end
            if (wr_hit[2])
            begin
                next_st.next_val = pwdata[15:0];
            end
            if (wr_hit[3])
            begin
                next_st.next_en = pwdata[15:0];
            end
        end
    end

    // clock enable low freezes every field, pins included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.sel <= pots_pkg::POTS_SEL_RESET;
            st.nonovl <= pots_pkg::POTS_MODE_RESET;
            st.next_val <= pots_pkg::POTS_NEXT_VAL_RESET;
            st.next_en <= pots_pkg::POTS_NEXT_EN_RESET;
            st.pins <= pots_pkg::POTS_PINS_RESET;
            st.rdata <= pots_pkg::POTS_RDATA_RESET;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    // zero wait states whenever the block runs
    always_comb
    begin
        pready = clk_en;
        pslverr = 1'b0;
        prdata = st.rdata;
        pattern_pin = st.pins;
    end
endmodule : pots_top

// *** tb/pots_sva.sv ***
// checker on pots_top ports
// assumes the bind at the foot
`timescale 1ns/1ps
module pots_sva(input wire logic pclk, presetn, clk_en, psel, penable, pwrite, input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, input wire pots_pkg::pots_match_t match, input wire logic [15:0] pattern_pin);
    logic [7:0] s;
    logic m;
    logic [15:0] e, p;
    logic [3:0] a, b;
    wire w = psel && penable && pwrite && clk_en, ta = a[s[7:6]], tb = b[s[7:6]];
    assign {a, b, p} = {match, pattern_pin};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {s, m, e} <= {8'hFF, 1'b0, 16'h0000};
        else if (w && paddr == pots_pkg::POTS_ADDR_SEL) s <= pwdata[7:0];
        else if (w && paddr == pots_pkg::POTS_ADDR_MODE) m <= pwdata[0];
        else if (w && paddr == pots_pkg::POTS_ADDR_NEXT_EN) e <= pwdata[15:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_g0_trig: assert property ($changed(p[3:0]) |-> $past(a[s[1:0]])) else $error("g0");
    a_g1_trig: assert property ($changed(p[7:4]) |-> $past(a[s[3:2]])) else $error("g1");
    a_g2_trig: assert property ($changed(p[11:8]) |-> $past(a[s[5:4]])) else $error("g2");
    a_g3_trig: assert property ($changed(p[15:12]) |-> $past(ta || m && tb)) else $error("g3");
    a_norm_hold: assert property ($past(!m && !ta) |-> $stable(p[15:12])) else $error("g3 hold");
    a_nonovl_fall: assert property ($past(m && ta && !tb) |-> (p[15:12] & ~$past(p[15:12])) == 4'h0)
        else $error("rise");
    a_en_mask: assert property (((p ^ $past(p)) & ~$past(e)) == 16'h0000) else $error("en");
    a_one_update: assert property ($past(!clk_en || a == 4'h0 && b == 4'h0) |-> $stable(p)) else $error("upd");
endmodule : pots_sva
bind pots_top pots_sva u_sva(.*);

// *** tb/pots_timer.sv ***
// timer partner: one-cycle compare match pulses
// assumes the bench holds fire for one cycle
`timescale 1ns/1ps
module pots_timer(input wire logic pclk, input wire logic [7:0] fire, output pots_pkg::pots_match_t match);
    always_ff @(posedge pclk) match <= fire;
endmodule : pots_timer

// *** tb/pulse_output_trigger_select_tb.sv ***
// bench: apb writes and timer pulses against pattern pins
// assumes pots_top and the pots_timer partner
`timescale 1ns/1ps
module pulse_output_trigger_select_tb;
logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready;
logic [11:0] paddr = '0;
logic [31:0] pwdata = '0, prdata;
logic [7:0] f = '0;
logic clk_en = 1'b1, pslverr;
logic [15:0] pattern_pin, r, x = '0, n, k, en = 16'hF7EF;
pots_pkg::pots_match_t match;
int err_count = 0, checks_done = 0;
pots_top u_dut(.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .match, .pattern_pin);
pots_timer u_tim(.pclk, .fire(f), .match);
initial forever #20 pclk = ~pclk;
task chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e)
    begin
        err_count++;
        $display("[FAIL] %0t %h %h", $time, g, e);
    end
endtask : chk
task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({15'h0000, pslverr}, 16'h0000);
    {r, psel, penable} <= {prdata[15:0], 2'b00};
    @(posedge pclk);
endtask : apb
task pulse(input logic [7:0] v);
    f <= v;
    @(posedge pclk) f <= '0;
    repeat (2) @(posedge pclk);
    chk(pattern_pin, x);
endtask : pulse
initial
begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, '0);
    chk(r, 16'h00FF);
    apb(1'b1, 12'h00C, en);
    for (int i = 0; i < 8; i++)
    begin
        n = ~x;
        k = 16'h000F << (4 * (i[2] ? 3 - i[1:0] : i[1:0]));
        apb(1'b1, 12'h000, i[2] ? 16'h001B : 16'h00E4);
        apb(1'b1, 12'h008, n);
        x = (n & en & k) | (x & ~(en & k));
        pulse(8'h10 << i[1:0]);
    end
    n = ~x;
    apb(1'b1, 12'h008, n);
    clk_en <= 1'b0;
    pulse(8'h10);
    clk_en <= 1'b1;
    apb(1'b1, 12'h000, 16'h00E4);
    pulse(8'h08);
    apb(1'b1, 12'h004, 16'h0001);
    x = x & ~(en & ~n & 16'hF000);
    pulse(8'h80);
    x = x | (en & n & 16'hF000);
    pulse(8'h08);
    apb(1'b1, 12'h010, ~x);
    apb(1'b0, 12'h010, '0);
    chk(r, x);
    apb(1'b0, 12'h004, '0);
    chk(r, 16'h0001);
    apb(1'b0, 12'h000, '0);
    chk(r, 16'h00E4);
    apb(1'b0, 12'h020, '0);
    chk(r, 16'h0000);
    presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, 12'h000, '0);
    chk(r, 16'h00FF);
    apb(1'b0, 12'h010, '0);
    chk(r, 16'h0000);
    results();
end
initial
begin
    #100000;
    err_count++;
    results();
end
task results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask : results
endmodule : pulse_output_trigger_select_tb
